// ### design/fcfs_top.sv
// Four channel fire sequencer: channel states, firing, inhibit and safety.
`timescale 1ns/1ps
// Operation
// (R1) Channel advance command cycles run, hold, stop, run.
// (R2) External mode fires only on the channel trigger input edges.
// (R3) New period accepted only if not shorter than recorder delay.
// (R4) Fixed firing shoots the programmed count at fixed period after inhibit ends.
// (R5) Toggle alternates shots between recorder and fire outputs, no delay.
// (R6) Fixed firing forces inhibit handling on.
// (R7) Strict inhibit with fixed firing gives no more than the count.
// (R8) Early or late options allow extra shots while no busy period.
// (R9) Each shot drives source trigger and, if enabled, delayed recorder trigger.
// (R10) Recorder delay steps up or down by one millisecond per command.
// (R11) Recorder delay change applies at once in every state.
// (R12) Open safety link stops all channels and raises alarm until closed.
// (R13) Global commands put all channels in stop, run or hold.
// (R14) Stop gives no pulses; indication period grows by ten seconds.
// (R15) Inhibit modes: 0 off, 1 strict, 2 start extra, 3 start and end.
// (R16) Internal run mode fires once per elapsed period, reloading each shot.
module fcfs_top
    import fcfs_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Channel and global commands
    input wire logic [NUM_CH-1:0] chan_adv_i,
    input wire logic all_stop_i,
    input wire logic all_run_i,
    input wire logic all_hold_i,
    // Channel configuration
    input wire logic [NUM_CH-1:0] ext_mode_i,
    input wire logic [NUM_CH-1:0] fixed_en_i,
    input wire logic [NUM_CH-1:0] toggle_en_i,
    input wire logic [NUM_CH-1:0] delay_en_i,
    input wire logic [2*NUM_CH-1:0] inh_mode_i,
    input wire logic [CW*NUM_CH-1:0] fixed_count_i,
    // Period and delay updates
    input wire logic [NUM_CH-1:0] period_wr_i,
    input wire logic [PW-1:0] period_data_i,
    input wire logic [NUM_CH-1:0] delay_up_i,
    input wire logic [NUM_CH-1:0] delay_dn_i,
    // Pins
    input wire logic inhibit_i,
    input wire logic safety_ok_i,
    input wire logic [NUM_CH-1:0] ext_trig_i,
    // Outputs
    output logic [NUM_CH-1:0] fire_o,
    output logic [NUM_CH-1:0] rec_trig_o,
    output logic [NUM_CH-1:0] ind_o,
    output logic [NUM_CH-1:0] period_rej_o,
    output logic alarm_o,
    output logic [2*NUM_CH-1:0] chan_state_o,
    output logic [DW*NUM_CH-1:0] delay_ms_o,
    output logic [PW*NUM_CH-1:0] period_ms_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [MSW-1:0] ms_cnt;
        logic tick;
        logic [2:0] inh_s;
        logic [1:0] saf_s;
        logic [NUM_CH-1:0] ext_s1;
        logic [NUM_CH-1:0] ext_s2;
        logic [NUM_CH-1:0] ext_s3;
        fcfs_ch_s [NUM_CH-1:0] ch;
    } fcfs_top_s;

    fcfs_top_s r;
    fcfs_top_s n;
    logic [NUM_CH-1:0] dly_pulse;

    logic safe;
    logic busy;
    logic busy_rise;
    logic busy_fall;
    logic [NUM_CH-1:0] ext_rise;
    fcfs_inh_e eff_inh [NUM_CH];

    assign safe = r.saf_s[1];
    assign busy = r.inh_s[1];
    assign busy_rise = r.inh_s[1] && !r.inh_s[2];
    assign busy_fall = !r.inh_s[1] && r.inh_s[2];
    assign ext_rise = r.ext_s2 & ~r.ext_s3;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic due;
        logic cand;
        logic extra;
        logic shot;
        logic tgl;
        logic [CW-1:0] cnt;
        logic [PW:0] lim;
        fcfs_inh_e inh;
        due = 1'b0;
        cand = 1'b0;
        extra = 1'b0;
        shot = 1'b0;
        tgl = 1'b0;
        cnt = '0;
        lim = '0;
        inh = INH_OFF;
        for (int c = 0; c < NUM_CH; c++) begin
            eff_inh[c] = INH_OFF;
        end
        n = r;
        n.tick = 1'b0;
        if (r.ms_cnt == MSW'(MS_CYCLES - 1)) begin
            n.ms_cnt = '0;
            n.tick = 1'b1;
        end else begin
            n.ms_cnt = r.ms_cnt + 1'b1;
        end
        n.inh_s = {r.inh_s[1:0], inhibit_i};
        n.saf_s = {r.saf_s[0], safety_ok_i};
        n.ext_s1 = ext_trig_i;
        n.ext_s2 = r.ext_s1;
        n.ext_s3 = r.ext_s2;
        for (int c = 0; c < NUM_CH; c++) begin
            n.ch[c].fire = 1'b0;
            n.ch[c].rec = 1'b0;
            n.ch[c].ind = 1'b0;
            n.ch[c].rej = 1'b0;
            n.ch[c].dly_go = 1'b0;
            inh = fcfs_inh_e'(inh_mode_i[2*c +: 2]); // R15
            if (fixed_en_i[c] && inh == INH_OFF) begin
                inh = INH_STRICT; // R6
            end
            eff_inh[c] = inh;
            cnt = fixed_count_i[CW*c +: CW];
            tgl = toggle_en_i[c] && fixed_en_i[c];

            // A lost safety link overrides every command.
            if (!safe) begin
                n.ch[c].state = ST_STOP; // R12
            end else if (all_stop_i) begin
                n.ch[c].state = ST_STOP; // R13
            end else if (all_run_i) begin
                n.ch[c].state = ST_RUN; // R13
            end else if (all_hold_i) begin
                n.ch[c].state = ST_HOLD; // R13
            end else if (chan_adv_i[c]) begin
                unique case (r.ch[c].state)
                    ST_RUN: n.ch[c].state = ST_HOLD; // R1
                    ST_HOLD: n.ch[c].state = ST_STOP; // R1
                    ST_STOP: n.ch[c].state = ST_RUN; // R1
                    default: n.ch[c].state = ST_STOP;
                endcase
            end

            if (period_wr_i[c]) begin
                if (period_data_i >= r.ch[c].delay) begin
                    n.ch[c].period = period_data_i; // R3
                end else begin
                    n.ch[c].rej = 1'b1; // R3
                end
            end

            if (delay_up_i[c] && !delay_dn_i[c] && r.ch[c].delay != '1) begin
                n.ch[c].delay = r.ch[c].delay + 1'b1; // R10 R11
            end else if (delay_dn_i[c] && !delay_up_i[c] && r.ch[c].delay != '0) begin
                n.ch[c].delay = r.ch[c].delay - 1'b1; // R10 R11
            end

            // Period timer; a zero period counts as one millisecond.
            due = 1'b0;
            if (r.tick) begin
                if (PW'(r.ch[c].per_cnt + 1'b1) >= r.ch[c].period) begin
                    due = 1'b1;
                    n.ch[c].per_cnt = '0; // R16
                end else begin
                    n.ch[c].per_cnt = r.ch[c].per_cnt + 1'b1;
                end
            end
            cand = ext_mode_i[c] ? ext_rise[c] : due; // R2
            extra = ((inh == INH_EARLY || inh == INH_BOTH) && busy_rise)
                || (inh == INH_BOTH && busy_fall); // R15

            if (fixed_en_i[c]) begin
                shot = 1'b0;
                if (busy_fall && cnt != '0) begin
                    shot = 1'b1; // R4
                    n.ch[c].left = cnt - 1'b1;
                    n.ch[c].per_cnt = '0;
                end else if (busy) begin
                    shot = extra;
                end else if (r.ch[c].left != '0) begin
                    if (cand) begin
                        shot = 1'b1; // R4
                        n.ch[c].left = r.ch[c].left - 1'b1;
                    end
                end else if (inh != INH_STRICT) begin
                    shot = cand || extra; // R8
                end else begin
                    shot = 1'b0; // R7
                end
            end else if (inh != INH_OFF && busy) begin
                shot = extra; // R15
            end else begin
                shot = cand || extra;
            end
            if (r.ch[c].state != ST_RUN || !safe) begin
                shot = 1'b0; // R14 R12
            end

            if (shot) begin
                if (!ext_mode_i[c]) begin
                    n.ch[c].per_cnt = '0; // R16
                end
                if (tgl) begin
                    n.ch[c].tog = !r.ch[c].tog; // R5
                    n.ch[c].rec = r.ch[c].tog; // R5
                    n.ch[c].fire = !r.ch[c].tog; // R5
                end else begin
                    n.ch[c].fire = 1'b1; // R9
                    n.ch[c].dly_go = delay_en_i[c]; // R9
                end
            end

            // Indication runs slower in hold and stop so the state is visible.
            unique case (r.ch[c].state)
                ST_RUN: lim = {1'b0, r.ch[c].period};
                ST_HOLD: lim = r.ch[c].period + (PW+1)'(HOLD_EXTRA_MS);
                default: lim = r.ch[c].period + (PW+1)'(STOP_EXTRA_MS); // R14
            endcase
            if (r.ch[c].state == ST_RUN) begin
                n.ch[c].ind = shot;
                n.ch[c].ind_cnt = '0;
            end else if (r.tick) begin
                if ((PW+1)'(r.ch[c].ind_cnt + 1'b1) >= lim) begin
                    n.ch[c].ind = 1'b1;
                    n.ch[c].ind_cnt = '0;
                end else begin
                    n.ch[c].ind_cnt = r.ch[c].ind_cnt + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= '0;
            r.saf_s <= {2{SAFE_RST}};
            for (int c = 0; c < NUM_CH; c++) begin
                r.ch[c].state <= STATE_RST;
                r.ch[c].period <= PERIOD_RST;
                r.ch[c].delay <= DELAY_RST;
            end
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // Recorder delay and outputs
    // ------------------------------------------------------------
    assign alarm_o = !safe; // R12

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        fcfs_rec_delay u_dly (
            .clk_sys_i(clk_sys_i),
            .rstn_i(rstn_i),
            .ms_tick_i(r.tick),
            .start_i(r.ch[c].dly_go),
            .delay_ms_i(r.ch[c].delay),
            .pulse_o(dly_pulse[c])
        );
        assign fire_o[c] = r.ch[c].fire;
        assign rec_trig_o[c] = r.ch[c].rec || dly_pulse[c];
        assign ind_o[c] = r.ch[c].ind;
        assign period_rej_o[c] = r.ch[c].rej;
        assign chan_state_o[2*c +: 2] = r.ch[c].state;
        assign delay_ms_o[DW*c +: DW] = r.ch[c].delay;
        assign period_ms_o[PW*c +: PW] = r.ch[c].period;

        sequence adv_cmd_s;
            safe && !all_stop_i && !all_run_i && !all_hold_i && chan_adv_i[c];
        endsequence

        state_cycle_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R1
            adv_cmd_s and r.ch[c].state == ST_STOP |=> r.ch[c].state == ST_RUN)
            else $error("stop did not advance to run");

        ext_only_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R2
            ext_mode_i[c] && !fixed_en_i[c] && !busy_rise && !busy_fall && !ext_rise[c]
            |=> !fire_o[c])
            else $error("external channel fired without trigger edge");

        period_reject_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R3
            period_wr_i[c] && period_data_i < r.ch[c].delay
            |=> period_rej_o[c] && $stable(r.ch[c].period))
            else $error("short period was not rejected");

        stop_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R14
            r.ch[c].state != ST_RUN |=> !fire_o[c] && !r.ch[c].rec)
            else $error("pulse issued outside run state");

        fixed_inh_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R6
            fixed_en_i[c] |-> eff_inh[c] != INH_OFF)
            else $error("fixed firing without inhibit handling");

        strict_limit_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R7
            fixed_en_i[c] && eff_inh[c] == INH_STRICT && r.ch[c].left == '0
            && !busy_fall |=> !fire_o[c] && !r.ch[c].rec)
            else $error("strict fixed firing exceeded its count");

        toggle_nodly_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R5
            toggle_en_i[c] && fixed_en_i[c] |=> !r.ch[c].dly_go)
            else $error("recorder delay started in toggle mode");

        delay_step_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R10
            delay_up_i[c] && !delay_dn_i[c] && r.ch[c].delay != '1
            |=> r.ch[c].delay == $past(r.ch[c].delay) + 1'b1)
            else $error("recorder delay did not step up by one");
    end

    // The alarm follows the synchronised link at once; the stop lands one edge later.
    safety_stop_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R12
        !safe |-> alarm_o ##1 chan_state_o == {NUM_CH{ST_STOP}} && fire_o == '0)
        else $error("channels not stopped on open safety link");

    global_run_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R13
        safe && all_run_i && !all_stop_i |=> chan_state_o == {NUM_CH{ST_RUN}})
        else $error("global run not applied to all channels");
endmodule : fcfs_top

// ### design/fcfs_pkg.sv
// Constants, types and state layouts for the four channel fire sequencer.
package fcfs_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_CH = 4;
    localparam int PW = 16;
    localparam int DW = 16;
    localparam int CW = 8;
    localparam int MSW = 17;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 10000;
    localparam int MS_PS = 1000000000;
    localparam int MS_CYCLES_DEF = MS_PS / CLK_PERIOD_PS;
    localparam int STOP_EXTRA_MS = 10000;
    localparam int HOLD_EXTRA_MS = 1000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_STOP} fcfs_state_e;
    typedef enum logic [1:0] {INH_OFF, INH_STRICT, INH_EARLY, INH_BOTH} fcfs_inh_e;

    typedef struct packed {
        fcfs_state_e state;
        logic [PW-1:0] period;
        logic [DW-1:0] delay;
        logic [PW-1:0] per_cnt;
        logic [PW:0] ind_cnt;
        logic [CW-1:0] left;
        logic tog;
        logic fire;
        logic rec;
        logic ind;
        logic rej;
        logic dly_go;
    } fcfs_ch_s;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam fcfs_state_e STATE_RST = ST_RUN;
    localparam logic [PW-1:0] PERIOD_RST = 16'h01F4;
    localparam logic [DW-1:0] DELAY_RST = 16'h0000;
    localparam logic SAFE_RST = 1'h1;
endpackage : fcfs_pkg

// ### design/fcfs_rec_delay.sv
// Recorder trigger delay timer for one channel, counted in milliseconds.
`timescale 1ns/1ps
module fcfs_rec_delay
    import fcfs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Timebase and start
    input wire logic ms_tick_i,
    input wire logic start_i,
    input wire logic [DW-1:0] delay_ms_i,
    // Delayed trigger
    output logic pulse_o
);
    typedef struct packed {
        logic busy;
        logic [DW-1:0] elapsed;
        logic pulse;
    } fcfs_dly_s;

    fcfs_dly_s r;
    fcfs_dly_s n;

    // The live delay value is compared on every cycle, so a change made
    // while a shot is pending moves that pending trigger as well.
    always_comb begin
        n = r;
        n.pulse = 1'b0;
        if (start_i) begin
            n.busy = 1'b1;
            n.elapsed = '0;
        end else if (r.busy && r.elapsed >= delay_ms_i) begin // R9 R11
            n.pulse = 1'b1;
            n.busy = 1'b0;
        end else if (r.busy && ms_tick_i) begin
            n.elapsed = r.elapsed + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign pulse_o = r.pulse;

    delay_reached_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R9
        pulse_o |-> $past(r.busy) && $past(r.elapsed) >= $past(delay_ms_i))
        else $error("recorder trigger before its delay elapsed");

    delay_start_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R9
        start_i |=> r.busy && r.elapsed == '0 && !pulse_o)
        else $error("recorder delay did not restart");
endmodule : fcfs_rec_delay

// ### tb/fcfs_far_end.sv
// Far-side model: inhibit source, safety link, external triggers, source and recorder counters.
`timescale 1ns/1ps
module fcfs_far_end
    import fcfs_pkg::*;
(
    // Clock
    input wire logic clk_sys_i,
    // Triggers from the sequencer
    input wire logic [NUM_CH-1:0] fire_i,
    input wire logic [NUM_CH-1:0] rec_trig_i,
    // Pins towards the sequencer
    output logic inhibit_o,
    output logic safety_ok_o,
    output logic [NUM_CH-1:0] ext_trig_o
);
    int fire_cnt [NUM_CH];
    int rec_cnt [NUM_CH];

    // ------------------------------------------------------------
    // Pin levels
    // ------------------------------------------------------------
    // The link is fitted and the survey system idle at power up.
    initial begin
        inhibit_o = 1'b0;
        safety_ok_o = 1'b1;
        ext_trig_o = '0;
        clear_counts();
    end

    // ------------------------------------------------------------
    // Source and recorder counters
    // ------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (fire_i[c] === 1'b1) fire_cnt[c]++;
            if (rec_trig_i[c] === 1'b1) rec_cnt[c]++;
        end
    end

    task clear_counts();
        for (int c = 0; c < NUM_CH; c++) begin
            fire_cnt[c] = 0;
            rec_cnt[c] = 0;
        end
    endtask : clear_counts

    task set_busy(input logic busy);
        inhibit_o = busy;
    endtask : set_busy

    task set_link(input logic ok);
        safety_ok_o = ok;
    endtask : set_link

    // A contact closure is held three clocks so that the input synchroniser always sees it.
    task trig_pulse(input int ch);
        ext_trig_o[ch] = 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1;
        ext_trig_o[ch] = 1'b0;
    endtask : trig_pulse
endmodule : fcfs_far_end

// ### tb/fcfs_bench.sv
// Self-checking bench for the four channel fire sequencer.
`timescale 1ns/1ps
module fcfs_bench;
    import fcfs_pkg::*;
    localparam int MS = 10;
    logic clk_sys_i, rstn_i, all_stop_i, all_run_i, all_hold_i, inhibit_i, safety_ok_i, alarm_o;
    logic [NUM_CH-1:0] chan_adv_i, ext_mode_i, fixed_en_i, toggle_en_i, delay_en_i;
    logic [NUM_CH-1:0] period_wr_i, delay_up_i, delay_dn_i, ext_trig_i;
    logic [NUM_CH-1:0] fire_o, rec_trig_o, ind_o, period_rej_o;
    logic [2*NUM_CH-1:0] inh_mode_i, chan_state_o;
    logic [CW*NUM_CH-1:0] fixed_count_i;
    logic [PW-1:0] period_data_i;
    logic [DW*NUM_CH-1:0] delay_ms_o;
    logic [PW*NUM_CH-1:0] period_ms_o;
    int mismatches, checked, n, rej_cnt, sum;
    int gk [3] = '{1, 3, 2};
    logic [7:0] gs [3] = '{8'hAA, 8'h55, 8'h00};

    // Short millisecond so that bursts and delays fit in a few hundred cycles.
    fcfs_top #(.MS_CYCLES(MS)) uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .chan_adv_i(chan_adv_i),
        .all_stop_i(all_stop_i), .all_run_i(all_run_i), .all_hold_i(all_hold_i), .ext_mode_i(ext_mode_i),
        .fixed_en_i(fixed_en_i), .toggle_en_i(toggle_en_i), .delay_en_i(delay_en_i), .inh_mode_i(inh_mode_i),
        .fixed_count_i(fixed_count_i), .period_wr_i(period_wr_i), .period_data_i(period_data_i),
        .delay_up_i(delay_up_i), .delay_dn_i(delay_dn_i), .inhibit_i(inhibit_i), .safety_ok_i(safety_ok_i),
        .ext_trig_i(ext_trig_i), .fire_o(fire_o), .rec_trig_o(rec_trig_o), .ind_o(ind_o),
        .period_rej_o(period_rej_o), .alarm_o(alarm_o), .chan_state_o(chan_state_o),
        .delay_ms_o(delay_ms_o), .period_ms_o(period_ms_o));

    fcfs_far_end u_far (.clk_sys_i(clk_sys_i), .fire_i(fire_o), .rec_trig_i(rec_trig_o),
        .inhibit_o(inhibit_i), .safety_ok_o(safety_ok_i), .ext_trig_o(ext_trig_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        if (period_rej_o[0] === 1'b1) rej_cnt++;
    end

    // ------------------------------------------------------------
    // Access and check tasks
    // ------------------------------------------------------------
    task tick(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask : tick

    task end_sim();
        if (mismatches == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    task cmp(input string name, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask : cmp

    function automatic logic pick(input int kind, input int ch);
        case (kind)
            0: pick = fire_o[ch];
            1: pick = rec_trig_o[ch];
            default: pick = alarm_o;
        endcase
    endfunction : pick

    // Waits for an output level; running out of the bound is a failure and ends the run.
    task wait_ev(input string name, input int kind, input int ch, input logic lvl, input int bound, output int cyc);
        cyc = 0;
        while (pick(kind, ch) !== lvl) begin
            if (cyc >= bound) begin
                cmp(name, 64'h1, 64'h0);
                end_sim();
            end else begin
                tick(1);
                cyc++;
            end
        end
    endtask : wait_ev

    // One command pulse, then one more edge so the registered answer is visible.
    task cmd(input int kind, input int ch);
        case (kind)
            0: chan_adv_i[ch] = 1'b1;
            1: all_stop_i = 1'b1;
            2: all_run_i = 1'b1;
            3: all_hold_i = 1'b1;
            4: delay_up_i[ch] = 1'b1;
            5: delay_dn_i[ch] = 1'b1;
            default: period_wr_i[ch] = 1'b1;
        endcase
        tick(1);
        {chan_adv_i, all_stop_i, all_run_i, all_hold_i} = '0;
        {delay_up_i, delay_dn_i, period_wr_i} = '0;
        tick(1);
    endtask : cmd

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {mismatches, checked, rej_cnt} = '0;
        rstn_i = 1'b0;
        {chan_adv_i, all_stop_i, all_run_i, all_hold_i, ext_mode_i, fixed_en_i, toggle_en_i} = '0;
        {delay_en_i, period_wr_i, delay_up_i, delay_dn_i, inh_mode_i, fixed_count_i, period_data_i} = '0;
        tick(20);
        rstn_i = 1'b1;
        tick(1);
        cmp("state rst", 64'h0, chan_state_o);
        cmp("period rst", {4{PERIOD_RST}}, period_ms_o);
        cmp("delay rst", 64'h0, delay_ms_o);
        cmp("alarm rst", 64'h0, alarm_o);
        for (int i = 1; i <= 3; i++) begin
            for (int c = 0; c < NUM_CH; c++) cmd(0, c);
            cmp("chan state", {4{2'(i % 3)}}, chan_state_o);
        end
        for (int i = 0; i < 3; i++) begin
            cmd(gk[i], 0);
            cmp("all state", gs[i], chan_state_o);
            cmd(4, 0);
            cmp("ch0 delay up", i + 1, delay_ms_o[15:0]);
        end
        cmd(5, 0);
        cmp("ch0 delay down", 64'h2, delay_ms_o[15:0]);
        for (int c = 1; c < NUM_CH; c++) begin
            cmd(4, c);
            cmp("delay up", 64'h1, delay_ms_o[DW*c +: DW]);
            cmd(5, c);
            cmp("delay down", 64'h0, delay_ms_o[DW*c +: DW]);
        end
        cmd(4, 0);
        period_data_i = 16'h0002;
        cmd(6, 0);
        cmp("ch0 period short", PERIOD_RST, period_ms_o[15:0]);
        cmp("ch0 reject", 64'h1, rej_cnt);
        period_data_i = 16'h0003;
        cmd(6, 0);
        cmp("ch0 period equal", 64'h3, period_ms_o[15:0]);
        period_data_i = 16'h0004;
        cmd(6, 0);
        cmp("ch0 period", 64'h4, period_ms_o[15:0]);
        cmp("ch0 reject once", 64'h1, rej_cnt);
        wait_ev("ch0 fire", 0, 0, 1'b1, 100, n);
        tick(1);
        wait_ev("ch0 fire", 0, 0, 1'b1, 100, n);
        cmp("ch0 gap", 4 * MS, n + 1);
        cmp("ch0 ind", 64'h1, ind_o[0]);
        delay_en_i = '1;
        tick(1);
        wait_ev("ch0 fire", 0, 0, 1'b1, 100, n);
        wait_ev("ch0 rec", 1, 0, 1'b1, 100, n);
        cmp("ch0 rec lag", 64'h1, (n >= 2 * MS) && (n <= 3 * MS + 4));
        delay_en_i = '0;
        cmd(0, 0);
        cmd(0, 0);
        u_far.clear_counts();
        tick(200);
        cmp("ch0 stop fires", 64'h0, u_far.fire_cnt[0] + u_far.rec_cnt[0]);
        cmd(0, 0);
        ext_mode_i = '1;
        period_data_i = 16'h0002;
        cmd(6, 1);
        u_far.clear_counts();
        tick(100);
        cmp("ch1 ext idle", 64'h0, u_far.fire_cnt[1]);
        cmp("ch0 ext idle", 64'h0, u_far.fire_cnt[0]);
        u_far.trig_pulse(1);
        tick(10);
        cmp("ch1 ext fire", 64'h1, u_far.fire_cnt[1]);
        ext_mode_i = 4'h2;
        cmd(6, 2);
        cmd(6, 3);
        u_far.set_busy(1'b1);
        tick(3);
        fixed_en_i[3:2] = 2'b11;
        fixed_count_i[31:16] = {8'h03, 8'h03};
        inh_mode_i[7:4] = 4'h4;
        tick(1);
        u_far.clear_counts();
        tick(100);
        cmp("ch2 forced inhibit", 64'h0, u_far.fire_cnt[2]);
        cmp("ch3 strict busy", 64'h0, u_far.fire_cnt[3]);
        u_far.set_busy(1'b0);
        wait_ev("ch3 burst start", 0, 3, 1'b1, 10, n);
        tick(300);
        cmp("ch3 strict burst", 64'h3, u_far.fire_cnt[3]);
        cmp("ch2 forced strict", 64'h3, u_far.fire_cnt[2]);
        inh_mode_i[7:6] = 2'h2;
        u_far.set_busy(1'b1);
        wait_ev("ch3 busy start", 0, 3, 1'b1, 10, n);
        tick(100);
        u_far.clear_counts();
        u_far.set_busy(1'b0);
        tick(300);
        cmp("ch3 extra shots", 64'h1, u_far.fire_cnt[3] > 3);
        inh_mode_i[7:6] = 2'h1;
        toggle_en_i[3] = 1'b1;
        fixed_count_i[31:24] = 8'h04;
        u_far.set_busy(1'b1);
        tick(100);
        u_far.clear_counts();
        u_far.set_busy(1'b0);
        wait_ev("ch3 toggle first", 0, 3, 1'b1, 10, n);
        tick(300);
        cmp("ch3 toggle fire", 64'h2, u_far.fire_cnt[3]);
        cmp("ch3 toggle rec", 64'h2, u_far.rec_cnt[3]);
        u_far.set_link(1'b0);
        wait_ev("alarm rise", 2, 0, 1'b1, 8, n);
        tick(2);
        cmp("safety state", 64'hAA, chan_state_o);
        cmd(2, 0);
        cmp("safety refuse", 64'hAA, chan_state_o);
        u_far.clear_counts();
        u_far.trig_pulse(1);
        tick(200);
        sum = 0;
        for (int c = 0; c < NUM_CH; c++) sum += u_far.fire_cnt[c] + u_far.rec_cnt[c];
        cmp("safety shots", 64'h0, sum);
        u_far.set_link(1'b1);
        wait_ev("alarm fall", 2, 0, 1'b0, 8, n);
        tick(2);
        cmp("link back state", 64'hAA, chan_state_o);
        cmd(2, 0);
        cmp("all run", 64'h0, chan_state_o);
        end_sim();
    end
endmodule : fcfs_bench
